// [hdl/supply_cfg_pkg.sv]
// Constants, field layouts and carrier types of the supply manager configuration logic.
// Assumes a serial bus engine outside that decodes each transaction into one command request.
package supply_cfg_pkg;
  localparam int NUM_CHAN = 8;
  localparam int FIRST_STRONG_ONLY_CHAN = 4;
  localparam int CLK_HZ = 20_000_000;
  // Command codes seen on the decoded request port.
  localparam logic [7:0] CMD_CHAN_CFG = 8'hd0;
  localparam logic [7:0] CMD_CHIP_CFG = 8'hd1;
  localparam logic [7:0] CMD_TRIM_DAC = 8'hd2;
  // Per-channel word fields.
  localparam int CH_POL_BIT = 0;
  localparam int CH_GAIN_BIT = 1;
  localparam int CH_WPD_BIT = 2;
  localparam int CH_WPU_BIT = 3;
  localparam int CH_DAC_MODE_LSB = 4;
  localparam int CH_RUN_SEL_BIT = 8;
  // Chip-wide byte fields.
  localparam int ALL_VINEN_WPU_DIS_BIT = 0;
  localparam int ALL_LONG_TIMEOUT_BIT = 1;
  localparam int ALL_PEC_BIT = 2;
  localparam int ALL_SHARE_BIT = 3;
  localparam int ALL_RUN0_POL_BIT = 4;
  localparam int ALL_RUN1_POL_BIT = 5;
  localparam int ALL_VIN_CLR_BIT = 6;
  localparam int ALL_FAULT_LOG_BIT = 7;
  localparam logic [15:0] CHAN_CFG_RST = 16'h0000;
  localparam logic [7:0] CHIP_CFG_RST = 8'h00;
  // Trim DAC usage codes.
  localparam logic [1:0] DAC_SERVO = 2'h0;
  localparam logic [1:0] DAC_UNUSED = 2'h1;
  localparam logic [1:0] DAC_IMMEDIATE = 2'h2;
  localparam logic [1:0] DAC_SOFT_ONLY = 2'h3;
  // Bus timeout, stretched by a shift of three for the long setting.
  localparam int BUS_TIMEOUT_MS = 25;
  localparam int TIMEOUT_SHIFT = 3;
  localparam int TIMEOUT_W = 24;
  localparam int PAGE_W = 8;
  localparam int CHAN_W = 3;

  typedef enum logic [2:0] {
    SC_IDLE = 3'b001,
    SC_CONNECT = 3'b010,
    SC_DONE = 3'b100
  } sc_state_t;

  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
    logic pec_present;
    logic pec_ok;
  } bus_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] data;
  } bus_rsp_t;

  typedef struct packed {
    logic weak_pullup;
    logic weak_pulldown;
    logic fast_pulldown;
  } pin_drive_t;
endpackage

// [hdl/channel_ctrl.sv]
// One channel's decode of its configuration word: pin drive, DAC settings, soft-connect, run select.
// Assumes the DAC block reports soft-connect completion with sc_done.
`timescale 1ns/1ps
module channel_ctrl #(
  parameter int CHAN = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration and status
  input wire logic [15:0] cfg,
  input wire logic chan_on,
  input wire logic rise_done,
  input wire logic fault_off,
  input wire logic sc_done,
  input wire logic run0_act,
  input wire logic run1_act,
  input wire logic inhibit,
  // Results
  output supply_cfg_pkg::pin_drive_t drive,
  output logic dac_gain_hi,
  output logic dac_noninv,
  output logic dac_connected,
  output logic sc_req,
  output logic dac_write_ok,
  output logic run_req
);
  import supply_cfg_pkg::*;

  sc_state_t state_q;
  pin_drive_t drive_q;
  logic gain_q, pol_q, run_q;
  logic [1:0] mode;
  logic weak_allowed, wpu_eff, wpd_eff, soft_mode, active;

  assign mode = cfg[CH_DAC_MODE_LSB +: 2];
  assign weak_allowed = (CHAN < FIRST_STRONG_ONLY_CHAN);
  assign wpu_eff = cfg[CH_WPU_BIT] & weak_allowed;
  assign wpd_eff = cfg[CH_WPD_BIT] & weak_allowed;
  assign soft_mode = (mode == DAC_SOFT_ONLY) || (mode == DAC_SERVO);
  assign active = chan_on & rise_done;

  // Soft-connect sequence; leaving the on state always drops the connection.
  always_ff @(posedge clk) begin
    if (srst || !chan_on) begin
      state_q <= SC_IDLE;
    end else begin
      case (state_q)
        SC_IDLE: if (active && soft_mode) state_q <= SC_CONNECT;
        SC_CONNECT: if (sc_done) state_q <= SC_DONE;
        SC_DONE: if (!soft_mode) state_q <= SC_IDLE;
        default: state_q <= SC_IDLE;
      endcase
    end
  end

  // Output-enable drive: on channels below 4, weak pull-up when on, weak pull-down only for a soft stop.
  always_ff @(posedge clk) begin
    if (srst) begin
      drive_q <= '{weak_pullup: 1'b0, weak_pulldown: 1'b0, fast_pulldown: 1'b1};
    end else if (chan_on) begin
      drive_q <= '{weak_pullup: wpu_eff, weak_pulldown: 1'b0, fast_pulldown: 1'b0};
    end else begin
      drive_q <= '{weak_pullup: 1'b0, weak_pulldown: wpd_eff & ~fault_off,
                   fast_pulldown: ~wpd_eff | fault_off};
    end
  end

  // DAC settings and run request are registered so the analog side sees clean levels.
  always_ff @(posedge clk) begin
    if (srst) begin
      gain_q <= 1'b0;
      pol_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      gain_q <= cfg[CH_GAIN_BIT];
      pol_q <= cfg[CH_POL_BIT];
      run_q <= (cfg[CH_RUN_SEL_BIT] ? run1_act : run0_act) & ~inhibit;
    end
  end

  assign drive = drive_q;
  assign dac_gain_hi = gain_q;
  assign dac_noninv = pol_q;
  assign run_req = run_q;
  assign sc_req = (state_q == SC_CONNECT);
  assign dac_connected = (state_q == SC_DONE) || (active && mode == DAC_IMMEDIATE);
  // In soft-only mode a write to the trim DAC must wait for the soft-connect to finish.
  assign dac_write_ok = (mode != DAC_SOFT_ONLY) || (state_q == SC_DONE);

  // Checks of the pin drive, the soft-connect gate and the DAC gain and polarity.
  high_chan_weak_a: assert property (@(posedge clk) disable iff (srst)
    !weak_allowed |-> ##1 !drive.weak_pullup && !drive.weak_pulldown) else $error("weak pull on high channel");
  on_drive_a: assert property (@(posedge clk) disable iff (srst)
    chan_on |=> drive.weak_pullup == $past(wpu_eff) && !drive.fast_pulldown) else $error("on drive wrong");
  fault_fast_a: assert property (@(posedge clk) disable iff (srst)
    !chan_on && fault_off |=> drive.fast_pulldown && !drive.weak_pulldown) else $error("fault not fast");
  // The gate may only open after the channel has stayed on through a full connect sequence.
  soft_gate_a: assert property (@(posedge clk) disable iff (srst)
    mode == DAC_SOFT_ONLY && dac_write_ok |-> $past(chan_on) && $past(chan_on, 2))
    else $error("DAC write open early");
  gain_pol_a: assert property (@(posedge clk) disable iff (srst)
    ##1 dac_gain_hi == $past(cfg[CH_GAIN_BIT]) && dac_noninv == $past(cfg[CH_POL_BIT]))
    else $error("gain or polarity stale");
  soft_done_c: cover property (@(posedge clk) disable iff (srst) state_q == SC_CONNECT ##1 state_q == SC_DONE);
endmodule // channel_ctrl

// [hdl/supply_manager_config_regs.sv]
// Configuration registers of the supply manager and the chip-wide behaviour they steer.
// Assumes a bus engine outside that frames transactions, checks PEC and hands one request per transaction.
`timescale 1ns/1ps
module supply_manager_config_regs #(
  parameter int TIMEOUT_CYCLES = supply_cfg_pkg::BUS_TIMEOUT_MS * (supply_cfg_pkg::CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Decoded command port
  input wire logic req_valid,
  input wire supply_cfg_pkg::bus_req_t req,
  input wire logic [supply_cfg_pkg::PAGE_W-1:0] page,
  output logic rsp_valid,
  output supply_cfg_pkg::bus_rsp_t rsp,
  // Bus timeout
  input wire logic bus_active,
  output logic bus_timeout,
  output logic long_timeout,
  // Input supply and fault status
  input wire logic vin_above_on,
  input wire logic vin_below_off,
  input wire logic fault_event,
  input wire logic vin_en_fault_off,
  output logic fault_log_req,
  output logic clear_faults,
  // Run pins
  input wire logic run_pin_0,
  input wire logic run_pin_1,
  // Shared clock pin, open drain
  input wire logic share_clk_in,
  output logic share_clk_out,
  output logic share_clk_oe_n,
  output logic all_off,
  // Input-enable pin
  output logic vin_en_out,
  output logic vin_en_oe_n,
  output logic vin_en_weak_pullup,
  // Channel status
  input wire logic [supply_cfg_pkg::NUM_CHAN-1:0] chan_on,
  input wire logic [supply_cfg_pkg::NUM_CHAN-1:0] rise_done,
  input wire logic [supply_cfg_pkg::NUM_CHAN-1:0] chan_fault_off,
  input wire logic [supply_cfg_pkg::NUM_CHAN-1:0] sc_done,
  // Channel controls
  output supply_cfg_pkg::pin_drive_t [supply_cfg_pkg::NUM_CHAN-1:0] out_drive,
  output logic [supply_cfg_pkg::NUM_CHAN-1:0] dac_gain_hi,
  output logic [supply_cfg_pkg::NUM_CHAN-1:0] dac_noninv,
  output logic [supply_cfg_pkg::NUM_CHAN-1:0] dac_connected,
  output logic [supply_cfg_pkg::NUM_CHAN-1:0] sc_req,
  output logic [supply_cfg_pkg::NUM_CHAN-1:0] run_req,
  // Trim DAC write strobe
  output logic dac_wr_valid,
  output logic [supply_cfg_pkg::CHAN_W-1:0] dac_wr_chan,
  output logic [15:0] dac_wr_data
);
  import supply_cfg_pkg::*;

  localparam logic [TIMEOUT_W-1:0] TO_BASE = TIMEOUT_W'(TIMEOUT_CYCLES);
  localparam logic [TIMEOUT_W-1:0] TO_LONG = TIMEOUT_W'(TIMEOUT_CYCLES << TIMEOUT_SHIFT);

  logic [15:0] chan_cfg_q [NUM_CHAN];
  logic [7:0] chip_cfg_q;
  logic [NUM_CHAN-1:0] dac_write_ok;
  logic rsp_valid_q, bus_timeout_q, timed_out_q, vin_ok_q, clear_q, log_q;
  logic share_drive_q, vin_en_out_q, vin_en_oe_n_q, vin_en_wpu_q;
  logic dac_wr_valid_q;
  logic [CHAN_W-1:0] dac_wr_chan_q;
  logic [15:0] dac_wr_data_q;
  bus_rsp_t rsp_q;
  logic [TIMEOUT_W-1:0] to_cnt_q, to_limit;
  logic [CHAN_W-1:0] sel_chan;
  logic run0_act, run1_act, share_inhibit, chan_sel_ok;
  logic do_chan_wr, do_chip_wr, do_dac_wr;

  // A write is refused when its PEC is wrong, or missing while PEC is required.
  function automatic logic pec_reject(input bus_req_t r, input logic pec_required);
    pec_reject = (r.pec_present && !r.pec_ok) || (pec_required && !r.pec_present);
  endfunction

  // Only pages that name a real channel reach the per-channel word.
  function automatic logic page_valid(input logic [PAGE_W-1:0] p);
    page_valid = (p < PAGE_W'(NUM_CHAN));
  endfunction

  assign sel_chan = page[CHAN_W-1:0];
  assign chan_sel_ok = page_valid(page);
  assign do_chan_wr = req_valid && req.write && req.code == CMD_CHAN_CFG && chan_sel_ok
                      && !pec_reject(req, chip_cfg_q[ALL_PEC_BIT]);
  // The chip-wide byte ignores the page entirely.
  assign do_chip_wr = req_valid && req.write && req.code == CMD_CHIP_CFG
                      && !pec_reject(req, chip_cfg_q[ALL_PEC_BIT]);
  assign do_dac_wr = req_valid && req.write && req.code == CMD_TRIM_DAC && chan_sel_ok
                     && dac_write_ok[sel_chan] && !pec_reject(req, chip_cfg_q[ALL_PEC_BIT]);

  // Per-channel configuration words.
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (srst) begin
        chan_cfg_q[i] <= CHAN_CFG_RST;
      end else if (do_chan_wr && sel_chan == CHAN_W'(i)) begin
        chan_cfg_q[i] <= req.data;
      end
    end
  end

  // Chip-wide configuration byte.
  always_ff @(posedge clk) begin
    if (srst) begin
      chip_cfg_q <= CHIP_CFG_RST;
    end else if (do_chip_wr) begin
      chip_cfg_q <= req.data[7:0];
    end
  end

  // One response per request, one cycle later; a refused request answers with ack low.
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_valid_q <= req_valid;
      rsp_q <= '0;
      if (req_valid) begin
        if (req.write) begin
          rsp_q.ack <= do_chan_wr || do_chip_wr || do_dac_wr;
        end else if (req.code == CMD_CHIP_CFG) begin
          rsp_q.ack <= 1'b1;
          rsp_q.data <= {8'h00, chip_cfg_q};
        end else if (req.code == CMD_CHAN_CFG && chan_sel_ok) begin
          rsp_q.ack <= 1'b1;
          rsp_q.data <= chan_cfg_q[sel_chan];
        end
      end
    end
  end

  // Trim DAC value is passed on to the converter as a registered strobe.
  always_ff @(posedge clk) begin
    if (srst) begin
      dac_wr_valid_q <= 1'b0;
      dac_wr_chan_q <= '0;
      dac_wr_data_q <= '0;
    end else begin
      dac_wr_valid_q <= do_dac_wr;
      if (do_dac_wr) begin
        dac_wr_chan_q <= sel_chan;
        dac_wr_data_q <= req.data;
      end
    end
  end

  // Bus timeout: the long setting trades slower recovery for room to write fault logs.
  assign to_limit = chip_cfg_q[ALL_LONG_TIMEOUT_BIT] ? TO_LONG : TO_BASE;
  always_ff @(posedge clk) begin
    if (srst || !bus_active) begin
      to_cnt_q <= '0;
      timed_out_q <= 1'b0;
      bus_timeout_q <= 1'b0;
    end else begin
      bus_timeout_q <= 1'b0;
      if (!timed_out_q) begin
        if (to_cnt_q >= to_limit - TIMEOUT_W'(1)) begin
          timed_out_q <= 1'b1;
          bus_timeout_q <= 1'b1;
        end else begin
          to_cnt_q <= to_cnt_q + TIMEOUT_W'(1);
        end
      end
    end
  end

  // Input supply state with hysteresis between the turn-on and turn-off thresholds.
  always_ff @(posedge clk) begin
    if (srst) begin
      vin_ok_q <= 1'b0;
      clear_q <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (!vin_ok_q && vin_above_on) begin
        vin_ok_q <= 1'b1;
        clear_q <= chip_cfg_q[ALL_VIN_CLR_BIT];
      end else if (vin_ok_q && vin_below_off) begin
        vin_ok_q <= 1'b0;
      end
    end
  end

  // Fault log request and shared-clock hold-down.
  always_ff @(posedge clk) begin
    if (srst) begin
      log_q <= 1'b0;
      share_drive_q <= 1'b0;
    end else begin
      log_q <= fault_event && chip_cfg_q[ALL_FAULT_LOG_BIT];
      share_drive_q <= chip_cfg_q[ALL_SHARE_BIT] && !vin_ok_q;
    end
  end

  // Input-enable pin: a fault forces it low, otherwise weak pull-up or three-state.
  always_ff @(posedge clk) begin
    if (srst) begin
      vin_en_out_q <= 1'b0;
      vin_en_oe_n_q <= 1'b1;
      vin_en_wpu_q <= 1'b0;
    end else begin
      vin_en_out_q <= 1'b0;
      vin_en_oe_n_q <= !vin_en_fault_off;
      vin_en_wpu_q <= !vin_en_fault_off && !chip_cfg_q[ALL_VINEN_WPU_DIS_BIT];
    end
  end

  // Run pin levels after polarity; a low pin starts the unit when the polarity bit is clear.
  assign run0_act = chip_cfg_q[ALL_RUN0_POL_BIT] ? run_pin_0 : !run_pin_0;
  assign run1_act = chip_cfg_q[ALL_RUN1_POL_BIT] ? run_pin_1 : !run_pin_1;
  // A low shared clock from any unit stops every channel when the inhibit is enabled.
  assign share_inhibit = chip_cfg_q[ALL_SHARE_BIT] && !share_clk_in;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    channel_ctrl #(
      .CHAN(c)
    ) u_chan (
      .clk(clk),
      .srst(srst),
      .cfg(chan_cfg_q[c]),
      .chan_on(chan_on[c]),
      .rise_done(rise_done[c]),
      .fault_off(chan_fault_off[c]),
      .sc_done(sc_done[c]),
      .run0_act(run0_act),
      .run1_act(run1_act),
      .inhibit(share_inhibit),
      .drive(out_drive[c]),
      .dac_gain_hi(dac_gain_hi[c]),
      .dac_noninv(dac_noninv[c]),
      .dac_connected(dac_connected[c]),
      .sc_req(sc_req[c]),
      .dac_write_ok(dac_write_ok[c]),
      .run_req(run_req[c])
    );
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign bus_timeout = bus_timeout_q;
  assign long_timeout = chip_cfg_q[ALL_LONG_TIMEOUT_BIT];
  assign fault_log_req = log_q;
  assign clear_faults = clear_q;
  assign share_clk_out = 1'b0;
  assign share_clk_oe_n = !share_drive_q;
  assign all_off = share_inhibit;
  assign vin_en_out = vin_en_out_q;
  assign vin_en_oe_n = vin_en_oe_n_q;
  assign vin_en_weak_pullup = vin_en_wpu_q;
  assign dac_wr_valid = dac_wr_valid_q;
  assign dac_wr_chan = dac_wr_chan_q;
  assign dac_wr_data = dac_wr_data_q;

  // Checks of the command port, the chip-wide byte and the pins that it steers.
  pec_refuse_a: assert property (@(posedge clk) disable iff (srst)
    req_valid && req.write && chip_cfg_q[ALL_PEC_BIT] && !req.pec_present |=> rsp_valid && !rsp.ack)
    else $error("write without PEC accepted");
  pec_optional_a: assert property (@(posedge clk) disable iff (srst)
    req_valid && req.write && req.code == CMD_CHIP_CFG && !chip_cfg_q[ALL_PEC_BIT] && !req.pec_present
    |=> rsp_valid && rsp.ack) else $error("write without PEC refused");
  refused_write_a: assert property (@(posedge clk) disable iff (srst)
    req_valid && req.write && pec_reject(req, chip_cfg_q[ALL_PEC_BIT]) |=> $stable(chip_cfg_q) && !dac_wr_valid)
    else $error("refused write took effect");
  chip_any_page_a: assert property (@(posedge clk) disable iff (srst)
    req_valid && !req.write && req.code == CMD_CHIP_CFG |=> rsp.ack && rsp.data[7:0] == $past(chip_cfg_q))
    else $error("chip byte read depends on page");
  dac_gate_a: assert property (@(posedge clk) disable iff (srst)
    req_valid && req.code == CMD_TRIM_DAC && chan_sel_ok && !dac_write_ok[sel_chan] |=> !dac_wr_valid)
    else $error("DAC written before soft-connect");
  share_hold_a: assert property (@(posedge clk) disable iff (srst)
    chip_cfg_q[ALL_SHARE_BIT] && !vin_ok_q ##1 chip_cfg_q[ALL_SHARE_BIT] |-> !share_clk_oe_n)
    else $error("shared clock not held low");
  share_release_a: assert property (@(posedge clk) disable iff (srst)
    !chip_cfg_q[ALL_SHARE_BIT] ##1 !chip_cfg_q[ALL_SHARE_BIT] |-> share_clk_oe_n)
    else $error("shared clock held while disabled");
  inhibit_off_a: assert property (@(posedge clk) disable iff (srst)
    share_inhibit [*2] |-> run_req == '0) else $error("channel runs during inhibit");
  vin_clear_a: assert property (@(posedge clk) disable iff (srst)
    clear_faults |-> $past(chip_cfg_q[ALL_VIN_CLR_BIT]) && $rose(vin_ok_q)) else $error("bad fault clear");
  fault_log_a: assert property (@(posedge clk) disable iff (srst)
    fault_event && !chip_cfg_q[ALL_FAULT_LOG_BIT] |=> !fault_log_req) else $error("log while disabled");
  fault_log_on_a: assert property (@(posedge clk) disable iff (srst)
    fault_event && chip_cfg_q[ALL_FAULT_LOG_BIT] |=> fault_log_req) else $error("fault log not requested");
  timeout_len_a: assert property (@(posedge clk) disable iff (srst)
    bus_timeout |-> to_cnt_q == to_limit - TIMEOUT_W'(1) && $past(bus_active)) else $error("timeout count wrong");
  vin_en_a: assert property (@(posedge clk) disable iff (srst)
    !vin_en_fault_off && chip_cfg_q[ALL_VINEN_WPU_DIS_BIT] ##1 chip_cfg_q[ALL_VINEN_WPU_DIS_BIT]
    |-> vin_en_oe_n && !vin_en_weak_pullup) else $error("input-enable not three-stated");
  vin_en_fault_a: assert property (@(posedge clk) disable iff (srst)
    vin_en_fault_off |=> !vin_en_oe_n && !vin_en_weak_pullup && !vin_en_out)
    else $error("input-enable not forced off");
  // Channel 0 on run pin 0 must follow the pin through the chosen polarity.
  run_pol_a: assert property (@(posedge clk) disable iff (srst)
    !share_inhibit && !chan_cfg_q[0][CH_RUN_SEL_BIT]
    |=> run_req[0] == ($past(chip_cfg_q[ALL_RUN0_POL_BIT]) ~^ $past(run_pin_0)))
    else $error("run pin 0 polarity");
  // Main scenarios that the bench is expected to reach.
  chip_write_c: cover property (@(posedge clk) disable iff (srst) do_chip_wr ##1 rsp.ack);
  timeout_c: cover property (@(posedge clk) disable iff (srst) bus_timeout && long_timeout);
  dac_write_c: cover property (@(posedge clk) disable iff (srst) dac_wr_valid);
  clear_c: cover property (@(posedge clk) disable iff (srst) clear_faults);
endmodule // supply_manager_config_regs

// [verif/host_model.sv]
// Host model that issues one decoded command per call on the request port.
// Assumes the bench calls xfer and that clk runs; all changes happen on falling edges.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk,
  // Request side
  output logic req_valid,
  output supply_cfg_pkg::bus_req_t req,
  output logic [supply_cfg_pkg::PAGE_W-1:0] page,
  // Answer side
  input wire logic rsp_valid,
  input wire supply_cfg_pkg::bus_rsp_t rsp
);
  import supply_cfg_pkg::*;
  logic pec_on = 1'b0;
  // The request port starts idle.
  initial begin
    req_valid = 1'b0;
    req = '0;
    page = '0;
  end
  // One transfer; bad 1 omits the check byte, bad 2 sends a wrong one, gap slows the host.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [7:0] pg,
                      input int gap, input int bad, output bus_rsp_t r, output logic v);
    repeat (gap + 1) @(negedge clk);
    page = pg;
    req = '{w, c, d, (pec_on && bad != 1) || bad == 2, bad != 2};
    req_valid = 1'b1;
    @(negedge clk);
    v = rsp_valid;
    r = rsp;
    if (w && c == CMD_CHIP_CFG && r.ack) pec_on = d[ALL_PEC_BIT];
    req_valid = 1'b0;
    req = ~req; // Released lines must not keep showing the last request.
  endtask
endmodule // host_model

// [verif/testbench.sv]
// Self-checking bench for the supply manager configuration registers.
// Assumes the host model owns the request port; the bench drives every other input on falling edges or 1 ns after one.
`timescale 1ns/1ps
module testbench;
  import supply_cfg_pkg::*;
  localparam int TMO = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid, rsp_valid, bus_active, bus_timeout, long_timeout, vin_above_on, vin_below_off;
  logic fault_event, vin_en_fault_off, fault_log_req, clear_faults, run_pin_0, run_pin_1, other_low;
  logic share_clk_out, share_clk_oe_n, all_off, vin_en_out, vin_en_oe_n, vin_en_weak_pullup, dac_wr_valid;
  logic [7:0] page, chan_on, rise_done, chan_fault_off, sc_done, dac_gain_hi, dac_noninv, dac_connected;
  logic [7:0] sc_req, run_req, ch;
  logic [2:0] dac_wr_chan;
  logic [15:0] dac_wr_data, rdat;
  logic [15:0] cw [8];
  bus_req_t req;
  bus_rsp_t rsp;
  pin_drive_t [7:0] out_drive;
  wire logic share_clk_in;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  // Open-drain shared clock with pull-up; another unit may pull it low.
  assign share_clk_in = (share_clk_oe_n | share_clk_out) & ~other_low;
  supply_manager_config_regs #(.TIMEOUT_CYCLES(TMO)) dut (.*);
  host_model host (.*);
  initial forever #25 clk = ~clk;
  // Hang guard, well above the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command with a random host pace; the answer must come and carry the expected ack.
  task automatic op(logic w, logic [7:0] c, logic [15:0] d, logic [7:0] pg, int bad, logic ak);
    bus_rsp_t r;
    logic v;
    host.xfer(w, c, d, pg, $urandom_range(1), bad, r, v);
    chk("rsp_valid", 1, v);
    chk("ack", ak, r.ack);
    rdat = r.data;
  endtask
  task automatic rd(logic [7:0] c, logic [7:0] pg, logic [15:0] e);
    op(1'b0, c, 16'h0000, pg, 0, 1'b1);
    chk("read", e, rdat);
  endtask
  // Expected output-enable pin drive of one channel.
  function automatic pin_drive_t exp_drv(logic [15:0] c, int p, logic on, logic flt);
    logic lo;
    lo = p < FIRST_STRONG_ONLY_CHAN;
    if (on) return '{c[CH_WPU_BIT] & lo, 1'b0, 1'b0};
    if (c[CH_WPD_BIT] & lo & !flt) return '{1'b0, 1'b1, 1'b0};
    return '{1'b0, 1'b0, 1'b1};
  endfunction
  initial begin
    {bus_active, vin_above_on, vin_below_off, fault_event, vin_en_fault_off, run_pin_0, run_pin_1} = '0;
    {other_low, chan_on, rise_done, chan_fault_off, sc_done} = '0;
    void'($urandom(32'h40b7));
    repeat (12) @(negedge clk);
    srst = 1'b0;
    chk("drive", 3'b001, out_drive[0]);
    rd(CMD_CHIP_CFG, 8'h00, 16'h0000);
    rd(CMD_CHAN_CFG, 8'h00, 16'h0000);
    $display("reset test done");
    // Chip-wide byte from random pages, some beyond the channel range; PEC kept off here.
    for (int i = 0; i < 6; i++) begin
      ch = 8'($urandom) & 8'hfb;
      op(1'b1, CMD_CHIP_CFG, {8'($urandom), ch}, 8'($urandom), 0, 1'b1);
      rd(CMD_CHIP_CFG, 8'($urandom), {8'h00, ch});
      repeat (2) @(negedge clk);
      chk("long", ch[1], long_timeout);
      chk("vin_pu", !ch[0], vin_en_weak_pullup);
      chk("vin_oe", 1, vin_en_oe_n);
      chk("share_oe", !ch[3], share_clk_oe_n);
      chk("all_off", ch[3], all_off);
    end
    $display("chip-wide test done");
    for (int p = 0; p < 8; p++) begin
      cw[p] = 16'($urandom);
      op(1'b1, CMD_CHAN_CFG, cw[p], 8'(p), 0, 1'b1);
    end
    op(1'b1, CMD_CHAN_CFG, 16'h1234, 8'h08, 0, 1'b0);
    op(1'b1, 8'h55, 16'h0000, 8'h00, 0, 1'b0);
    for (int p = 0; p < 8; p++) rd(CMD_CHAN_CFG, 8'(p), cw[p]);
    // Random channel states and run pins against each stored word.
    repeat (4) begin
      chan_on = 8'($urandom);
      chan_fault_off = 8'($urandom) & ~chan_on;
      run_pin_0 = 1'($urandom);
      run_pin_1 = 1'($urandom);
      repeat (3) @(negedge clk);
      for (int p = 0; p < 8; p++) begin
        chk("drive", exp_drv(cw[p], p, chan_on[p], chan_fault_off[p]), out_drive[p]);
        chk("gain", cw[p][CH_GAIN_BIT], dac_gain_hi[p]);
        chk("pol", cw[p][CH_POL_BIT], dac_noninv[p]);
        chk("run", (cw[p][8] ? run_pin_1 == ch[5] : run_pin_0 == ch[4]) & !ch[3], run_req[p]);
      end
    end
    $display("channel test done");
    // Input supply, shared clock, fault log and input-enable, with features on and then off.
    for (int k = 0; k < 2; k++) begin
      ch = k ? 8'h00 : 8'hc8;
      op(1'b1, CMD_CHIP_CFG, {8'h00, ch}, 8'h00, 0, 1'b1);
      vin_below_off = 1'b1;
      @(negedge clk);
      vin_below_off = 1'b0;
      repeat (2) @(negedge clk);
      chk("share_oe", !ch[3], share_clk_oe_n);
      chk("all_off", ch[3], all_off);
      fault_event = 1'b1;
      @(negedge clk);
      fault_event = 1'b0;
      chk("log", ch[7], fault_log_req);
      vin_above_on = 1'b1;
      n = 0;
      repeat (4) begin
        @(negedge clk);
        n += clear_faults;
      end
      vin_above_on = 1'b0;
      chk("clear", ch[6], n);
      chk("share_oe", 1, share_clk_oe_n);
      chk("share_out", 0, share_clk_out);
      other_low = 1'b1;
      #1;
      chk("all_off", ch[3], all_off);
      other_low = 1'b0;
      vin_en_fault_off = 1'b1;
      repeat (2) @(negedge clk);
      chk("vin_oe", 0, vin_en_oe_n);
      chk("vin_out", 0, vin_en_out);
      vin_en_fault_off = 1'b0;
    end
    $display("supply test done");
    for (int k = 0; k < 2; k++) begin
      op(1'b1, CMD_CHIP_CFG, {14'h0000, k[0], 1'b0}, 8'h00, 0, 1'b1);
      bus_active = 1'b1;
      n = 0;
      while (!bus_timeout && n < 400) begin
        @(negedge clk);
        n++;
      end
      bus_active = 1'b0;
      chk("timeout", 1, n >= (TMO << 3 * k) - 2 && n <= (TMO << 3 * k) + 2);
      @(negedge clk);
    end
    $display("timeout test done");
    // Check byte made mandatory: missing or wrong ones refuse writes.
    op(1'b1, CMD_CHIP_CFG, 16'h0004, 8'h00, 0, 1'b1);
    op(1'b1, CMD_CHAN_CFG, 16'h00aa, 8'h00, 1, 1'b0);
    op(1'b1, CMD_CHAN_CFG, 16'h00bb, 8'h00, 2, 1'b0);
    rd(CMD_CHAN_CFG, 8'h00, cw[0]);
    op(1'b1, CMD_CHAN_CFG, 16'h0030, 8'h00, 0, 1'b1);
    op(1'b1, CMD_CHAN_CFG, 16'h0020, 8'h01, 0, 1'b1);
    op(1'b1, CMD_CHIP_CFG, 16'h0000, 8'h00, 0, 1'b1);
    $display("check byte test done");
    chan_on = 8'h03;
    rise_done = 8'h03;
    repeat (3) @(negedge clk);
    chk("sc_req", 1, sc_req[0]);
    chk("sc_req", 0, sc_req[1]);
    chk("connected", 1, dac_connected[1]);
    op(1'b1, CMD_TRIM_DAC, 16'h0123, 8'h00, 0, 1'b0);
    chk("dac_wr", 0, dac_wr_valid);
    op(1'b0, CMD_TRIM_DAC, 16'h0000, 8'h00, 0, 1'b0);
    sc_done = 8'h01;
    repeat (3) @(negedge clk);
    chk("connected", 1, dac_connected[0]);
    op(1'b1, CMD_TRIM_DAC, 16'h0123, 8'h00, 0, 1'b1);
    chk("dac_wr", 1, dac_wr_valid);
    chk("dac_chan", 0, dac_wr_chan);
    chk("dac_data", 16'h0123, dac_wr_data);
    $display("soft-connect test done");
    wrap_up();
  end
endmodule // testbench
